/* hdl/mfu_dev_end.sv */
// device end: serial port, reset handling, digital output and gain select
//
// Overview of operation
// R01 - reset pin low past 120 us halts everything
// R02 - release runs init loading default settings
// R03 - two-line asynchronous full-duplex link
// R04 - start, eight data LSB first, stop
// R05 - rate equals divisor times clock over 524288
// R06 - default 600 bit/s after reset
// R07 - rates up to 512K; host never faster
// R08 - send on own TX, receive on RX
// R09 - output pin shows pulse, irq, zc or direction
// R10 - current gain 10x or 50x; voltage fixed
// R11 - idle high, falling edge start, mid-bit sampling
`timescale 1ns/100ps
`default_nettype none
module mfu_dev_end #(
    parameter int RESET_MIN = mfu_pkg::RESET_MIN_CYC, // reset pin hold, cycles
    parameter int INIT_LEN  = mfu_pkg::INIT_CYC       // init sequence, cycles
) (
    input  wire logic                      ref_clk,      // 40 MHz clock
    input  wire logic                      rstn,         // async reset, active low
    mfu_link_if.dev                        link,         // serial link pins
    input  wire logic [7:0]                tx_data,      // byte to send
    input  wire logic                      tx_valid,     // byte offered
    output logic                           tx_ready,     // byte taken this cycle
    output logic [7:0]                     rx_data,      // byte received
    output logic                           rx_valid,     // one-cycle receive pulse
    output logic                           rx_frame_err, // stop bit was low
    input  wire logic [mfu_pkg::DIV_W-1:0] div_in,       // new bit_rate_divisor
    input  wire logic                      div_we,       // load div_in
    input  wire logic                      gain_in,      // 1 selects 50x
    input  wire logic [1:0]                func_in,      // output function code
    input  wire logic                      cfg_we,       // load gain_in, func_in
    input  wire logic                      energy_pulse, // energy pulse source
    input  wire logic                      irq_level,    // interrupt source
    input  wire logic                      zero_cross,   // zero-crossing source
    input  wire logic                      energy_dir,   // energy direction source
    output logic                           digital_out,  // configurable output
    output logic                           cur_gain_x50, // current_gain_stage at 50x
    output logic [mfu_pkg::DIV_W-1:0]      bit_rate_divisor, // active divisor
    output logic                           running       // init done, link live
);

    // =====
    // pin synchronisers
    localparam int HOLD_W = $clog2(RESET_MIN + 1);
    localparam int INIT_W = $clog2(INIT_LEN + 1);

    logic [1:0]           rst_s_r;
    logic [1:0]           rx_s_r;
    logic                 rx_prev_r;
    logic [HOLD_W-1:0]    hold_r;
    logic [INIT_W-1:0]    init_r;
    mfu_pkg::mfu_dev_st_t st_r;
    logic                 pin_low;
    logic                 rx_line;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s_r <= 2'b11;
            rx_s_r  <= 2'b11;
        end else begin
            rst_s_r <= {rst_s_r[0], link.reset_n_pin};
            rx_s_r  <= {rx_s_r[0], link.host_tx};
        end
    end

    assign pin_low = ~rst_s_r[1];
    assign rx_line = rx_s_r[1]; // [R08]

    // =====
    // reset pin timing and init sequence
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= '0;
        end else if (!pin_low) begin
            hold_r <= '0;
        end else if (hold_r != HOLD_W'(RESET_MIN)) begin
            hold_r <= hold_r + 1'b1;
        end
    end

    // short glitches below the hold time are ignored entirely
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r   <= mfu_pkg::MFU_ST_INIT;
            init_r <= '0;
        end else begin
            case (st_r)
                mfu_pkg::MFU_ST_HALT: begin
                    init_r <= '0;
                    if (!pin_low) st_r <= mfu_pkg::MFU_ST_INIT; // [R02]
                end
                mfu_pkg::MFU_ST_INIT: begin
                    init_r <= init_r + 1'b1;
                    if (init_r == INIT_W'(INIT_LEN - 1)) st_r <= mfu_pkg::MFU_ST_RUN;
                end
                mfu_pkg::MFU_ST_RUN: begin
                    init_r <= '0;
                end
                default: st_r <= mfu_pkg::MFU_ST_HALT;
            endcase
            if (hold_r == HOLD_W'(RESET_MIN)) st_r <= mfu_pkg::MFU_ST_HALT; // [R01]
        end
    end

    assign running = (st_r == mfu_pkg::MFU_ST_RUN);

    // =====
    // settings: defaults while halted or initialising
    mfu_pkg::mfu_gain_t    gain_r;
    mfu_pkg::mfu_do_func_t func_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_rate_divisor <= mfu_pkg::DIV_DEFAULT;
        end else if (!running) begin
            bit_rate_divisor <= mfu_pkg::DIV_DEFAULT; // [R01] [R02] [R06]
        end else if (div_we) begin
            bit_rate_divisor <= div_in; // [R05]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gain_r <= mfu_pkg::GAIN_DEFAULT;
            func_r <= mfu_pkg::FUNC_DEFAULT;
        end else if (!running) begin
            gain_r <= mfu_pkg::GAIN_DEFAULT; // [R02]
            func_r <= mfu_pkg::FUNC_DEFAULT;
        end else if (cfg_we) begin
            gain_r <= mfu_pkg::mfu_gain_t'(gain_in); // [R10]
            func_r <= mfu_pkg::mfu_do_func_t'(func_in);
        end
    end

    // voltage gain is fixed at 10x, so only current gain leaves the block
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur_gain_x50 <= 1'b0;
            digital_out  <= 1'b0;
        end else begin
            cur_gain_x50 <= (gain_r == mfu_pkg::MFU_GAIN_X50); // [R10]
            case (func_r) // [R09]
                mfu_pkg::MFU_OUT_ENERGY: digital_out <= running & energy_pulse;
                mfu_pkg::MFU_OUT_IRQ:    digital_out <= running & irq_level;
                mfu_pkg::MFU_OUT_ZC:     digital_out <= running & zero_cross;
                mfu_pkg::MFU_OUT_DIR:    digital_out <= running & energy_dir;
                default:                 digital_out <= 1'b0;
            endcase
        end
    end

    // =====
    // 16x oversample tick
    logic [mfu_pkg::ACC_W-1:0] acc_r;
    logic [mfu_pkg::ACC_W:0]   step;
    logic                      tick;

    assign step = mfu_pkg::mfu_ovs_step(acc_r, bit_rate_divisor); // [R05]
    assign tick = step[mfu_pkg::ACC_W];

    // divisors above half scale saturate to one tick per clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            acc_r <= '0;
        end else if (!running) begin
            acc_r <= '0;
        end else begin
            acc_r <= step[mfu_pkg::ACC_W-1:0]; // [R07]
        end
    end

    // =====
    // transmitter, runs independently of the receiver
    logic [9:0] tx_sh_r;
    logic [3:0] tx_ph_r;
    logic [3:0] tx_cnt_r;
    logic       tx_busy_r;

    assign tx_ready    = running & ~tx_busy_r;
    assign link.dev_tx = tx_sh_r[0]; // [R03] [R08]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_r   <= mfu_pkg::LINE_IDLE;
            tx_ph_r   <= 4'h0;
            tx_cnt_r  <= 4'h0;
            tx_busy_r <= 1'b0;
        end else if (!running) begin
            tx_sh_r   <= mfu_pkg::LINE_IDLE; // [R11]
            tx_ph_r   <= 4'h0;
            tx_cnt_r  <= 4'h0;
            tx_busy_r <= 1'b0;
        end else if (!tx_busy_r) begin
            if (tx_valid) begin
                tx_sh_r   <= {1'b1, tx_data, 1'b0}; // [R04]
                tx_ph_r   <= 4'h0;
                tx_cnt_r  <= 4'h0;
                tx_busy_r <= 1'b1;
            end
        end else if (tick) begin
            tx_ph_r <= tx_ph_r + 1'b1;
            if (tx_ph_r == mfu_pkg::OVS_LAST) begin
                tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                tx_cnt_r <= tx_cnt_r + 1'b1;
                if (tx_cnt_r == 4'h9) tx_busy_r <= 1'b0; // [R04]
            end
        end
    end

    // =====
    // receiver
    mfu_pkg::mfu_rx_st_t rx_st_r;
    logic [3:0]          rx_ph_r;
    logic [2:0]          rx_cnt_r;
    logic [7:0]          rx_sh_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_prev_r <= 1'b1;
        end else begin
            rx_prev_r <= rx_line;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_r      <= mfu_pkg::MFU_RX_IDLE;
            rx_ph_r      <= 4'h0;
            rx_cnt_r     <= 3'h0;
            rx_sh_r      <= 8'h00;
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            rx_frame_err <= 1'b0;
        end else if (!running) begin
            rx_st_r  <= mfu_pkg::MFU_RX_IDLE;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            case (rx_st_r)
                mfu_pkg::MFU_RX_IDLE: begin
                    rx_ph_r <= 4'h0;
                    if (rx_prev_r && !rx_line) rx_st_r <= mfu_pkg::MFU_RX_START; // [R11]
                end
                mfu_pkg::MFU_RX_START: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_MID) begin
                        rx_ph_r  <= 4'h0;
                        rx_cnt_r <= 3'h0;
                        rx_st_r  <= rx_line ? mfu_pkg::MFU_RX_IDLE : mfu_pkg::MFU_RX_DATA;
                    end
                end
                mfu_pkg::MFU_RX_DATA: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_LAST) begin
                        rx_sh_r  <= {rx_line, rx_sh_r[7:1]}; // [R04] [R11]
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                        if (rx_cnt_r == mfu_pkg::LAST_DATA) rx_st_r <= mfu_pkg::MFU_RX_STOP;
                    end
                end
                mfu_pkg::MFU_RX_STOP: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_LAST) begin
                        rx_data      <= rx_sh_r;
                        rx_valid     <= 1'b1;
                        rx_frame_err <= ~rx_line; // [R04]
                        rx_st_r      <= mfu_pkg::MFU_RX_IDLE;
                    end
                end
                default: rx_st_r <= mfu_pkg::MFU_RX_IDLE;
            endcase
        end
    end

endmodule // mfu_dev_end
`default_nettype wire

/* hdl/mfu_host_end.sv */
// host end: serial port facing the front end and reset pin driver
`timescale 1ns/100ps
`default_nettype none
module mfu_host_end #(
    parameter int RESET_HOLD = mfu_pkg::RESET_MIN_CYC + 8 // pin low time, cycles
) (
    input  wire logic                      ref_clk,      // 40 MHz clock
    input  wire logic                      rstn,         // async reset, active low
    mfu_link_if.host                       link,         // serial link pins
    input  wire logic                      reset_req,    // pulse: reset the device
    input  wire logic [7:0]                tx_data,      // byte to send
    input  wire logic                      tx_valid,     // byte offered
    output logic                           tx_ready,     // byte taken this cycle
    output logic [7:0]                     rx_data,      // byte received
    output logic                           rx_valid,     // one-cycle receive pulse
    output logic                           rx_frame_err, // stop bit was low
    input  wire logic [mfu_pkg::DIV_W-1:0] div_in,       // new divisor, clamped
    input  wire logic                      div_we,       // load div_in
    output logic [mfu_pkg::DIV_W-1:0]      div_active    // divisor in use
);

    // =====
    // reset pin and divisor
    localparam int HOLD_W = $clog2(RESET_HOLD + 1);

    logic [HOLD_W-1:0] hold_r;
    logic              busy;

    assign link.reset_n_pin = (hold_r == '0);
    assign busy             = (hold_r != '0);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= '0;
        end else if (reset_req && !busy) begin
            hold_r <= HOLD_W'(RESET_HOLD); // [R01]
        end else if (busy) begin
            hold_r <= hold_r - 1'b1;
        end
    end

    // after a device reset the host falls back to the default rate
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_active <= mfu_pkg::DIV_DEFAULT;
        end else if (busy) begin
            div_active <= mfu_pkg::DIV_DEFAULT; // [R06]
        end else if (div_we) begin
            div_active <= (div_in > mfu_pkg::DIV_MAX) ? mfu_pkg::DIV_MAX : div_in; // [R07]
        end
    end

    logic [mfu_pkg::ACC_W-1:0] acc_r;
    logic [mfu_pkg::ACC_W:0]   step;
    logic                      tick;

    assign step = mfu_pkg::mfu_ovs_step(acc_r, div_active); // [R05]
    assign tick = step[mfu_pkg::ACC_W];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) acc_r <= '0;
        else       acc_r <= busy ? '0 : step[mfu_pkg::ACC_W-1:0];
    end

    // =====
    // transmitter
    logic [9:0] tx_sh_r;
    logic [3:0] tx_ph_r;
    logic [3:0] tx_cnt_r;
    logic       tx_busy_r;

    assign tx_ready     = ~busy & ~tx_busy_r;
    assign link.host_tx = tx_sh_r[0]; // [R03] [R08]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_r   <= mfu_pkg::LINE_IDLE; // [R11]
            tx_ph_r   <= 4'h0;
            tx_cnt_r  <= 4'h0;
            tx_busy_r <= 1'b0;
        end else if (!tx_busy_r) begin
            if (tx_valid && !busy) begin
                tx_sh_r   <= {1'b1, tx_data, 1'b0}; // [R04]
                tx_ph_r   <= 4'h0;
                tx_cnt_r  <= 4'h0;
                tx_busy_r <= 1'b1;
            end
        end else if (tick) begin
            tx_ph_r <= tx_ph_r + 1'b1;
            if (tx_ph_r == mfu_pkg::OVS_LAST) begin
                tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                tx_cnt_r <= tx_cnt_r + 1'b1;
                if (tx_cnt_r == 4'h9) tx_busy_r <= 1'b0;
            end
        end
    end

    // =====
    // receiver
    logic [1:0]          rx_s_r;
    logic                rx_prev_r;
    mfu_pkg::mfu_rx_st_t rx_st_r;
    logic [3:0]          rx_ph_r;
    logic [2:0]          rx_cnt_r;
    logic [7:0]          rx_sh_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_s_r    <= 2'b11;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s_r    <= {rx_s_r[0], link.dev_tx}; // [R08]
            rx_prev_r <= rx_s_r[1];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_r      <= mfu_pkg::MFU_RX_IDLE;
            rx_ph_r      <= 4'h0;
            rx_cnt_r     <= 3'h0;
            rx_sh_r      <= 8'h00;
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            case (rx_st_r)
                mfu_pkg::MFU_RX_IDLE: begin
                    rx_ph_r <= 4'h0;
                    if (rx_prev_r && !rx_s_r[1]) rx_st_r <= mfu_pkg::MFU_RX_START; // [R11]
                end
                mfu_pkg::MFU_RX_START: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_MID) begin
                        rx_ph_r  <= 4'h0;
                        rx_cnt_r <= 3'h0;
                        rx_st_r  <= rx_s_r[1] ? mfu_pkg::MFU_RX_IDLE : mfu_pkg::MFU_RX_DATA;
                    end
                end
                mfu_pkg::MFU_RX_DATA: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_LAST) begin
                        rx_sh_r  <= {rx_s_r[1], rx_sh_r[7:1]}; // [R04]
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                        if (rx_cnt_r == mfu_pkg::LAST_DATA) rx_st_r <= mfu_pkg::MFU_RX_STOP;
                    end
                end
                mfu_pkg::MFU_RX_STOP: if (tick) begin
                    rx_ph_r <= rx_ph_r + 1'b1;
                    if (rx_ph_r == mfu_pkg::OVS_LAST) begin
                        rx_data      <= rx_sh_r;
                        rx_valid     <= 1'b1;
                        rx_frame_err <= ~rx_s_r[1];
                        rx_st_r      <= mfu_pkg::MFU_RX_IDLE;
                    end
                end
                default: rx_st_r <= mfu_pkg::MFU_RX_IDLE;
            endcase
        end
    end

endmodule // mfu_host_end
`default_nettype wire

/* hdl/mfu_link_if.sv */
// two-line serial link plus reset pin between host and metering front end
`timescale 1ns/100ps
`default_nettype none
interface mfu_link_if;
    logic dev_tx;      // device transmit line, host receives it
    logic host_tx;     // host transmit line, device receives it
    logic reset_n_pin; // device reset pin, active low
    modport dev (output dev_tx, input host_tx, input reset_n_pin);
    modport host (input dev_tx, output host_tx, output reset_n_pin);
endinterface
`default_nettype wire

/* hdl/mfu_pkg.sv */
// constants, types and helpers for the serial link
package mfu_pkg;

    // =====
    // clock and timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int CLK_PER_US   = CLK_HZ / 1_000_000;
    localparam int RESET_MIN_US = 120;
    localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_PER_US;
    localparam int INIT_CYC     = 16;

    // =====
    // bit rate: rate = divisor * clk / RATE_SCALE
    localparam int  DIV_W        = 16;
    localparam int  ACC_W        = 19;
    localparam longint RATE_SCALE = 524288;
    localparam longint DEF_BAUD   = 600;
    localparam longint MAX_BAUD   = 512000;
    localparam logic [DIV_W-1:0] DIV_DEFAULT =
        DIV_W'((DEF_BAUD * RATE_SCALE + CLK_HZ / 2) / CLK_HZ);
    localparam logic [DIV_W-1:0] DIV_MAX =
        DIV_W'((MAX_BAUD * RATE_SCALE) / CLK_HZ);
    localparam logic [3:0] OVS_PAD  = 4'h0;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hf;

    // =====
    // framing
    localparam logic [2:0] LAST_DATA = 3'h7;
    localparam logic [9:0] LINE_IDLE = 10'h3ff;

    // =====
    // types
    typedef enum logic [1:0] {
        MFU_OUT_ENERGY = 2'h0,
        MFU_OUT_IRQ    = 2'h1,
        MFU_OUT_ZC     = 2'h2,
        MFU_OUT_DIR    = 2'h3
    } mfu_do_func_t;
    typedef enum logic {
        MFU_GAIN_X10 = 1'b0,
        MFU_GAIN_X50 = 1'b1
    } mfu_gain_t;
    localparam mfu_do_func_t FUNC_DEFAULT = MFU_OUT_ENERGY;
    localparam mfu_gain_t    GAIN_DEFAULT = MFU_GAIN_X10;
    typedef enum logic [2:0] {
        MFU_ST_HALT = 3'b001,
        MFU_ST_INIT = 3'b010,
        MFU_ST_RUN  = 3'b100
    } mfu_dev_st_t;
    typedef enum logic [3:0] {
        MFU_RX_IDLE  = 4'b0001,
        MFU_RX_START = 4'b0010,
        MFU_RX_DATA  = 4'b0100,
        MFU_RX_STOP  = 4'b1000
    } mfu_rx_st_t;

    // 16x oversample phase step; top bit is the tick
    function automatic logic [ACC_W:0] mfu_ovs_step(
        input logic [ACC_W-1:0] acc,
        input logic [DIV_W-1:0] div
    );
        logic [ACC_W+1:0] s;
        s = {2'b00, acc} + {1'b0, div, OVS_PAD};
        return {|s[ACC_W+1:ACC_W], s[ACC_W-1:0]};
    endfunction

endpackage

/* test/metering_frontend_uart_host_port_bench.sv */
// bench joining device and host ends
`timescale 1ns/100ps
`default_nettype none
module metering_frontend_uart_host_port_bench;
    logic        ref_clk = 1'b0, rstn = 1'b0, rreq = 1'b0, dtv = 1'b0, htv = 1'b0;
    logic        dwe = 1'b0, hwe = 1'b0, gain = 1'b0, cwe = 1'b0;
    logic [7:0]  dtd = 8'h00, htd = 8'h00;
    logic [15:0] div = 16'h0000, dacc = 16'h0000, hacc = 16'h0000;
    logic [1:0]  func = 2'h0;
    logic [3:0]  src = 4'h0;
    logic        dtr, htr, drv, hrv, dfe, hfe, dout, gx50, run;
    logic [7:0]  drd, hrd;
    logic [15:0] ddiv, hdiv;
    int          dn = 0, hn = 0, w, bad_count = 0, num_checks = 0;
    mfu_link_if link ();
    always #12.5 ref_clk = ~ref_clk;
    // =====
    // last two bytes received, oldest high
    always @(posedge ref_clk) begin
        if (drv === 1'b1) begin
            dacc <= {dacc[7:0], drd};
            dn <= dn + 1;
        end
        if (hrv === 1'b1) begin
            hacc <= {hacc[7:0], hrd};
            hn <= hn + 1;
        end
    end
    mfu_dev_end #(.RESET_MIN(20)) u_mfu_dev_end (
        .ref_clk, .rstn, .link(link.dev), .tx_data(dtd), .tx_valid(dtv),
        .tx_ready(dtr), .rx_data(drd), .rx_valid(drv), .rx_frame_err(dfe),
        .div_in(div), .div_we(dwe), .gain_in(gain), .func_in(func), .cfg_we(cwe),
        .energy_pulse(src[0]), .irq_level(src[1]), .zero_cross(src[2]),
        .energy_dir(src[3]), .digital_out(dout), .cur_gain_x50(gx50),
        .bit_rate_divisor(ddiv), .running(run));
    mfu_host_end #(.RESET_HOLD(40)) u_mfu_host_end (
        .ref_clk, .rstn, .link(link.host), .reset_req(rreq), .tx_data(htd),
        .tx_valid(htv), .tx_ready(htr), .rx_data(hrd), .rx_valid(hrv),
        .rx_frame_err(hfe), .div_in(div), .div_we(hwe), .div_active(hdiv));
    mfu_link_assertions #(.BIT_CYC(128), .RESET_MIN(20)) u_mfu_link_assertions (
        .ref_clk, .rstn, .dev_tx(link.dev_tx), .host_tx(link.host_tx),
        .reset_n_pin(link.reset_n_pin));
    // =====
    // tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang(input int tries, input int lim);
        if (tries >= lim) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic wait_run(input logic want);
        int i;
        for (i = 0; i < 400 && run !== want; i++) @(negedge ref_clk);
        hang(i, 400);
    endtask
    task automatic set_div(input logic [15:0] v, input logic both);
        @(posedge ref_clk);
        div <= v;
        hwe <= 1'b1;
        dwe <= both;
        @(posedge ref_clk);
        hwe <= 1'b0;
        dwe <= 1'b0;
        @(negedge ref_clk);
    endtask
    // device frames are also sampled on the wire mid-bit
    task automatic send(input logic host, input logic [7:0] b);
        int i;
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(posedge ref_clk);
        if (host) htd <= b;
        else dtd <= b;
        if (host) htv <= 1'b1;
        else dtv <= 1'b1;
        for (i = 0; i < 3000 && (host ? htr : dtr) !== 1'b1; i++) @(negedge ref_clk);
        hang(i, 3000);
        @(posedge ref_clk);
        if (host) htv <= 1'b0;
        else dtv <= 1'b0;
        if (!host) begin
            repeat (64) @(negedge ref_clk);
            for (i = 0; i < 10; i++) begin
                check("device line bit", {15'h0, fr[i]}, {15'h0, link.dev_tx});
                repeat (128) @(negedge ref_clk);
            end
        end
    endtask
    // =====
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        wait_run(1'b1);
        check("running", 16'h0001, {15'h0, run});
        check("device divisor", 16'h0008, ddiv);
        check("host divisor", 16'h0008, hdiv);
        check("gain", 16'h0000, {15'h0, gx50});
        set_div(16'hffff, 1'b0);
        check("host clamp", 16'h1a36, hdiv);
        set_div(16'h1000, 1'b1);
        check("device divisor", 16'h1000, ddiv);
        check("host divisor", 16'h1000, hdiv);
        fork
            begin send(1'b0, 8'ha5); send(1'b0, 8'h5a); end
            begin send(1'b1, 8'h3c); send(1'b1, 8'hc3); end
        join
        for (w = 0; w < 4000 && !(dn == 2 && hn == 2); w++) @(negedge ref_clk);
        hang(w, 4000);
        check("device received", 16'h3cc3, dacc);
        check("host received", 16'ha55a, hacc);
        check("frame errors", 16'h0000, {14'h0, dfe, hfe});
        check("idle lines", 16'h0003, {14'h0, link.dev_tx, link.host_tx});
        for (int f = 0; f < 4; f++) begin
            @(posedge ref_clk);
            func <= f[1:0];
            gain <= f[0];
            cwe <= 1'b1;
            src <= 4'h1 << f;
            @(posedge ref_clk);
            cwe <= 1'b0;
            repeat (2) @(negedge ref_clk);
            check("output on", 16'h0001, {15'h0, dout});
            check("gain", {15'h0, f[0]}, {15'h0, gx50});
            @(posedge ref_clk);
            src <= ~(4'h1 << f);
            repeat (2) @(negedge ref_clk);
            check("output off", 16'h0000, {15'h0, dout});
        end
        @(posedge ref_clk);
        rreq <= 1'b1;
        @(posedge ref_clk);
        rreq <= 1'b0;
        wait_run(1'b0);
        check("halted", 16'h0000, {15'h0, run});
        wait_run(1'b1);
        check("device divisor", 16'h0008, ddiv);
        check("gain", 16'h0000, {15'h0, gx50});
        complete_run();
    end
endmodule // metering_frontend_uart_host_port_bench
`default_nettype wire

/* test/mfu_link_assertions.sv */
// checks on the link wires
`timescale 1ns/100ps
`default_nettype none
module mfu_link_assertions #(
    parameter int BIT_CYC   = 128, // clocks per bit at the test divisor
    parameter int RESET_MIN = 20   // device halt threshold, cycles
) (
    input wire logic ref_clk,    // 40 MHz clock
    input wire logic rstn,       // async reset, active low
    input wire logic dev_tx,     // device line
    input wire logic host_tx,    // host line
    input wire logic reset_n_pin // device reset pin
);
    // =====
    // frame position trackers; assume no frame at default rate
    localparam int MID  = BIT_CYC / 2;
    localparam int STOP = 9 * BIT_CYC + MID;
    int dpos_r, hpos_r, plow_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) dpos_r <= 0;
        else if (dpos_r == STOP) dpos_r <= 0;
        else if (dpos_r != 0 || $fell(dev_tx)) dpos_r <= dpos_r + 1;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) hpos_r <= 0;
        else if (hpos_r == STOP) hpos_r <= 0;
        else if (hpos_r != 0 || $fell(host_tx)) hpos_r <= hpos_r + 1;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn || reset_n_pin) plow_r <= 0;
        else if (plow_r < 1000) plow_r <= plow_r + 1;
    end
    // =====
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_dev_low;   !dev_tx [*8];  endsequence
    sequence s_dev_high;  dev_tx [*8];   endsequence
    sequence s_host_low;  !host_tx [*8]; endsequence
    sequence s_host_high; host_tx [*8];  endsequence
    property p_dev_start; dpos_r == MID |-> !dev_tx; endproperty
    property p_dev_stop; dpos_r == STOP |-> s_dev_high; endproperty
    property p_dev_edge; dpos_r == 1 |-> s_dev_low; endproperty
    property p_host_start; hpos_r == MID |-> !host_tx; endproperty
    property p_host_stop; hpos_r == STOP |-> s_host_high; endproperty
    property p_host_edge; hpos_r == 1 |-> s_host_low; endproperty
    property p_pin_hold; $fell(reset_n_pin) |-> !reset_n_pin [*8]; endproperty
    property p_halt_idle; plow_r >= RESET_MIN + 4 |-> dev_tx; endproperty
    a_dev_start: assert property (p_dev_start)
        else $error("device start bit not low");
    a_dev_stop: assert property (p_dev_stop)
        else $error("device stop bit not high");
    a_dev_edge: assert property (p_dev_edge)
        else $error("device start bit too short");
    a_host_start: assert property (p_host_start)
        else $error("host start bit not low");
    a_host_stop: assert property (p_host_stop)
        else $error("host stop bit not high");
    a_host_edge: assert property (p_host_edge)
        else $error("host start bit too short");
    a_pin_hold: assert property (p_pin_hold)
        else $error("reset pin pulse too short");
    a_halt_idle: assert property (p_halt_idle)
        else $error("device line busy while halted");
endmodule // mfu_link_assertions
`default_nettype wire
